// ===== pin_change_interrupt_unit.sv
// Pin change interrupt unit: 32 pins in four groups, AHB-Lite registers, vector requests.
//
// Functional notes
// - Any enabled change on pins 24 to 31 sets group flag 3.
// - Any enabled change on pins 16 to 23 sets group flag 2.
// - Any enabled change on pins 8 to 15 sets group flag 1.
// - Any enabled change on pins 0 to 7 sets group flag 0.
// - A set flag requests its vector only with global and group enable both one.
// - A flag clears when the processor starts that group's routine.
// - Writing one to a flag bit clears it; writing zero leaves it.
// - Mask at index 0x73, eight bits, reset 0, enables pins 24 to 31.
// - Mask at index 0x6D, eight bits, reset 0, enables pins 16 to 23.
// - Mask at index 0x6C, eight bits, reset 0, enables pins 8 to 15.
// - Mask at index 0x6B, eight bits, reset 0, enables pins 0 to 7.
// - A pin with mask bit zero never affects its flag or request.
// - Control register holds four group enables in bits 3 to 0.
// - Detection runs only on the running I/O clock; a stopped clock sees nothing.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module pin_change_interrupt_unit #(
    parameter int GROUPS = pin_change_pkg::GROUPS,
    parameter int PINS_PER_GROUP = pin_change_pkg::PINS_PER_GROUP,
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Pins
    input wire logic [GROUPS*PINS_PER_GROUP-1:0] change_pins_i,
    // Processor core
    input wire logic global_irq_enable_i,
    input wire logic [GROUPS-1:0] vector_ack_i,
    output logic [GROUPS-1:0] irq_req_o
);

    localparam int PIN_COUNT = GROUPS * PINS_PER_GROUP;
    localparam int IDX_W = pin_change_pkg::IDX_W;
    localparam int BA_W = pin_change_pkg::BYTE_ADDR_W;
    // One stage more than the synchroniser, so the previous sample is filled as well.
    localparam logic [1:0] WARM_DONE = 2'(pin_change_pkg::SYNC_STAGES + 1);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [BA_W-1:0] byte_addr(input logic [IDX_W-1:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    function automatic logic [IDX_W-1:0] mask_idx(input int g);
        unique case (g)
            0: mask_idx = pin_change_pkg::MASK_GROUP0_IDX;
            1: mask_idx = pin_change_pkg::MASK_GROUP1_IDX;
            2: mask_idx = pin_change_pkg::MASK_GROUP2_IDX;
            default: mask_idx = pin_change_pkg::MASK_GROUP3_IDX;
        endcase
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic [PINS_PER_GROUP-1:0] mask [GROUPS];
    logic [GROUPS-1:0] group_enable;
    logic [GROUPS-1:0] flags;
    logic [PIN_COUNT-1:0] pin_now;
    logic [PIN_COUNT-1:0] pin_prev;
    logic [1:0] warm;
    pin_change_pkg::bus_phase_s phase;
    pin_change_pkg::group_state_s gstate;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire addr_take = hsel_i && hready_i && htrans_i == pin_change_pkg::HTRANS_NONSEQ;
    wire addr_high_zero = (haddr_i >> BA_W) == '0;
    wire [IDX_W-1:0] addr_idx = haddr_i[BA_W-1:2];
    wire word_aligned = haddr_i[BA_W-1:0] == byte_addr(addr_idx);
    wire addr_ok = addr_high_zero && word_aligned;
    wire [IDX_W-1:0] data_idx = phase.idx;
    wire data_write = phase.valid && phase.write;
    wire [PINS_PER_GROUP-1:0] wr_byte = hwdata_i[pin_change_pkg::REG_DATA_LSB +: PINS_PER_GROUP];
    wire [GROUPS-1:0] wr_group = hwdata_i[pin_change_pkg::GROUP_FIELD_LSB +: GROUPS];
    wire wr_control = data_write && data_idx == pin_change_pkg::CONTROL_IDX;
    wire wr_flags = data_write && data_idx == pin_change_pkg::FLAGS_IDX;
    wire [GROUPS-1:0] wr_mask;
    wire [GROUPS-1:0] rd_mask_hit;

    genvar gv;
    generate
        for (gv = 0; gv < GROUPS; gv++) begin : g_dec
            assign wr_mask[gv] = data_write && data_idx == mask_idx(gv);
            assign rd_mask_hit[gv] = addr_idx == mask_idx(gv);
        end
    endgenerate

    // Read data is registered in the address phase, so a write in the
    // preceding data phase is not seen by a read issued back to back.
    logic [31:0] rd_value;
    always_comb begin
        rd_value = '0;
        if (addr_ok) begin
            for (int g = 0; g < GROUPS; g++) begin
                if (rd_mask_hit[g]) begin
                    rd_value[pin_change_pkg::REG_DATA_LSB +: PINS_PER_GROUP] = mask[g];
                end
            end
            if (addr_idx == pin_change_pkg::CONTROL_IDX) begin
                rd_value[pin_change_pkg::GROUP_FIELD_LSB +: GROUPS] = gstate.enable;
            end
            if (addr_idx == pin_change_pkg::FLAGS_IDX) begin
                rd_value[pin_change_pkg::GROUP_FIELD_LSB +: GROUPS] = gstate.flag;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase <= '0;
            hrdata_o <= '0;
            hreadyout_o <= 1'b1;
            hresp_o <= pin_change_pkg::HRESP_OKAY;
        end else begin
            phase.valid <= addr_take && addr_ok;
            phase.write <= hwrite_i;
            phase.idx <= addr_idx;
            hrdata_o <= (addr_take && !hwrite_i) ? rd_value : '0;
            hreadyout_o <= 1'b1;
            hresp_o <= pin_change_pkg::HRESP_OKAY;
        end
    end

    // ****************************************************************
    // Registers written by software
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int g = 0; g < GROUPS; g++) begin
                mask[g] <= pin_change_pkg::MASK_RESET;
            end
            group_enable <= pin_change_pkg::CONTROL_RESET;
        end else begin
            for (int g = 0; g < GROUPS; g++) begin
                if (wr_mask[g]) begin
                    mask[g] <= wr_byte;
                end
            end
            if (wr_control) begin
                group_enable <= wr_group;
            end
        end
    end

    // ****************************************************************
    // Pin sampling and change detection
    // ****************************************************************
    // Detection runs only while ref_clk_i runs, so a stopped clock sees no change.
    pin_sync #(
        .WIDTH(PIN_COUNT),
        .STAGES(pin_change_pkg::SYNC_STAGES)
    ) pin_sync_inst (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .async_i(change_pins_i),
        .sync_o(pin_now)
    );

    // Comparison is held off until the synchroniser and the previous sample have filled, otherwise
    // a pin that sits high at reset would look like a change.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_prev <= '0;
            warm <= '0;
        end else begin
            pin_prev <= pin_now;
            if (warm != WARM_DONE) begin
                warm <= warm + 2'd1;
            end
        end
    end

    wire compare_ok = warm == WARM_DONE;
    wire [PIN_COUNT-1:0] pin_changed = compare_ok ? (pin_now ^ pin_prev) : '0;
    wire [PIN_COUNT-1:0] mask_flat;
    wire [GROUPS-1:0] group_hit;

    generate
        for (gv = 0; gv < GROUPS; gv++) begin : g_hit
            assign mask_flat[gv*PINS_PER_GROUP +: PINS_PER_GROUP] = mask[gv];
            assign group_hit[gv] = |(pin_changed[gv*PINS_PER_GROUP +: PINS_PER_GROUP] & mask[gv]);
        end
    endgenerate

    // ****************************************************************
    // Flags and vector requests
    // ****************************************************************
    wire [GROUPS-1:0] sw_clear = wr_flags ? wr_group : '0;
    // A new change in the clearing cycle keeps the flag set.
    wire [GROUPS-1:0] next_flags = (flags & ~sw_clear & ~vector_ack_i) | group_hit;
    wire [GROUPS-1:0] next_irq_req = next_flags & group_enable & {GROUPS{global_irq_enable_i}};

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags <= pin_change_pkg::FLAGS_RESET;
            irq_req_o <= '0;
        end else begin
            flags <= next_flags;
            irq_req_o <= next_irq_req;
        end
    end

    assign gstate.flag = flags;
    assign gstate.enable = group_enable;

    // ****************************************************************
    // Checks
    // ****************************************************************
    request_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        irq_req_o == (flags & $past(group_enable) & {GROUPS{$past(global_irq_enable_i)}}))
        else $error("request does not follow flag and enables");

    masked_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (pin_changed & mask_flat) == '0 |=> (flags & ~$past(flags)) == '0)
        else $error("flag set with no enabled pin change");

    flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        group_hit[GROUPS-1] |=> flags[GROUPS-1])
        else $error("top group flag missed a change");

    low_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (|(pin_changed[PINS_PER_GROUP-1:0] & mask[0])) |=> flags[0])
        else $error("group zero flag missed a change");

    ack_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        vector_ack_i[0] && !group_hit[0] |=> !flags[0])
        else $error("flag survived its routine entry");

    w1c_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_flags && !wr_group[1] && !vector_ack_i[1] && flags[1] |=> flags[1])
        else $error("writing zero cleared a flag");

    mask_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_mask[GROUPS-1] |=> mask[GROUPS-1] == $past(wr_byte))
        else $error("mask write not stored");

    flags_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        addr_take && !hwrite_i && addr_ok && addr_idx == pin_change_pkg::FLAGS_IDX
        |=> hrdata_o[31:GROUPS] == '0 && hrdata_o[GROUPS-1:0] == $past(flags))
        else $error("flag read shows wrong bits");

    change_detect_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        compare_ok && $changed(pin_now) |-> pin_changed != '0)
        else $error("sampled pin change not detected");

    bus_okay_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        hreadyout_o && hresp_o == pin_change_pkg::HRESP_OKAY)
        else $error("slave stalled or answered with error");

    mid_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        group_hit[2] |=> flags[2])
        else $error("group two flag missed a change");

    second_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        group_hit[1] |=> flags[1])
        else $error("group one flag missed a change");

    mask2_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_mask[2] |=> mask[2] == $past(wr_byte))
        else $error("group two mask write not stored");

    mask1_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_mask[1] |=> mask[1] == $past(wr_byte))
        else $error("group one mask write not stored");

    mask0_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_mask[0] |=> mask[0] == $past(wr_byte))
        else $error("group zero mask write not stored");

    control_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_control |=> group_enable == $past(wr_group))
        else $error("control write not stored");

    control_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        addr_take && !hwrite_i && addr_ok && addr_idx == pin_change_pkg::CONTROL_IDX
        |=> hrdata_o[31:GROUPS] == '0 && hrdata_o[GROUPS-1:0] == $past(group_enable))
        else $error("control read shows wrong bits");

    mask_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        addr_take && !hwrite_i && addr_ok && addr_idx == pin_change_pkg::MASK_GROUP3_IDX
        |=> hrdata_o[31:PINS_PER_GROUP] == '0
        && hrdata_o[PINS_PER_GROUP-1:0] == $past(mask[GROUPS-1]))
        else $error("top mask read shows wrong bits");

    all_ack_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (vector_ack_i & ~group_hit) != '0 |=> (flags & $past(vector_ack_i & ~group_hit)) == '0)
        else $error("a served flag stayed set");

    all_w1c_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_flags |=> (flags & $past(wr_group & ~group_hit)) == '0)
        else $error("writing one left a flag set");

    // A flag may only drop through an acknowledge or a software clear.
    flag_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        flags != '0 |=> ($past(flags & ~vector_ack_i & ~sw_clear) & ~flags) == '0)
        else $error("flag dropped with no clear");

    warm_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !compare_ok |-> pin_changed == '0)
        else $error("change seen before the synchroniser filled");

    warm_stays_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        compare_ok |=> compare_ok)
        else $error("change detection switched off again");

    read_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !(addr_take && !hwrite_i) |=> hrdata_o == '0)
        else $error("read data outside a read data phase");

    request_off_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !global_irq_enable_i |=> irq_req_o == '0)
        else $error("request with global enable off");

    group_request_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (irq_req_o & ~flags) == '0)
        else $error("request without its flag");

    group_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (irq_req_o & ~$past(group_enable)) == '0)
        else $error("request without its group enable");

    addr_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        addr_take && !addr_ok |=> !phase.valid)
        else $error("bad address started a data phase");

endmodule

// ===== pin_change_pkg.sv
// Shared constants, register map and bus carrier types for the pin change interrupt unit.
package pin_change_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int GROUPS = 4;
    localparam int PINS_PER_GROUP = 8;
    localparam int PIN_COUNT = GROUPS * PINS_PER_GROUP;
    localparam int SYNC_STAGES = 2;

    // ****************************************************************
    // Register indices; the byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] MASK_GROUP0_IDX = 8'h6b;
    localparam logic [7:0] MASK_GROUP1_IDX = 8'h6c;
    localparam logic [7:0] MASK_GROUP2_IDX = 8'h6d;
    localparam logic [7:0] MASK_GROUP3_IDX = 8'h73;
    localparam logic [7:0] CONTROL_IDX = 8'h70;
    localparam logic [7:0] FLAGS_IDX = 8'h71;
    localparam int IDX_W = 8;
    localparam int BYTE_ADDR_W = IDX_W + 2;

    // ****************************************************************
    // Reset values and field layout
    // ****************************************************************
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam int GROUP_FIELD_LSB = 0;
    localparam int REG_DATA_LSB = 0;

    // ****************************************************************
    // Bus encodings
    // ****************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    // Address-phase capture carried into the data phase.
    typedef struct packed {
        logic valid;
        logic write;
        logic [IDX_W-1:0] idx;
    } bus_phase_s;

    // Per-group view of the interrupt state.
    typedef struct packed {
        logic [GROUPS-1:0] flag;
        logic [GROUPS-1:0] enable;
    } group_state_s;

endpackage

// ===== pin_sync.sv
// Two-stage synchroniser bank for asynchronous pin inputs.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 32,
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Pins in, samples out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage [STAGES];

    // The first stage feeds only the next stage, so metastability cannot leak into logic.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= '0;
            end
        end else begin
            stage[0] <= async_i;
            for (int i = 1; i < STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign sync_o = stage[STAGES-1];

endmodule

// ===== core_model.sv
// Processor-side partner model: starts vector routines a programmable number of cycles late.
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Requests in, routine starts out
    input wire logic [3:0] irq_req_i,
    input wire logic auto_ack_i,
    input wire logic [7:0] ack_wait_i,
    output logic [3:0] vector_ack_o
);
    // ****************************************************************
    // Vector service
    // ****************************************************************
    logic [7:0] wait_cnt;
    // A core enters one vector at a time, so only the lowest pending group is served.
    wire logic [3:0] first_req = irq_req_i & (~irq_req_i + 4'h1);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_cnt <= 8'h00;
            vector_ack_o <= 4'h0;
        end else begin
            vector_ack_o <= 4'h0;
            if (vector_ack_o != 4'h0 || !auto_ack_i || irq_req_i == 4'h0) begin
                wait_cnt <= 8'h00;
            end else if (wait_cnt >= ack_wait_i) begin
                vector_ack_o <= first_req;
                wait_cnt <= 8'h00;
            end else begin
                wait_cnt <= wait_cnt + 8'h01;
            end
        end
    end
endmodule

// ===== pin_change_interrupt_unit_test.sv
// Self-checking testbench for the pin change interrupt unit.
`timescale 1ns/1ps
module pin_change_interrupt_unit_test;
    // ****************************************************************
    // Stimulus, partner and design
    // ****************************************************************
    logic ref_clk_i, rstn_i, hsel, hwrite, glob, auto_ack, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, pins;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] ack_wait;
    logic [3:0] ack, irq;
    int bad_count = 0;
    int comparisons = 0;
    int acks = 0;
    typedef struct packed {int grp; int pin; logic [7:0] mask; logic [3:0] ctrl; logic gie;
        logic [3:0] irq; logic [31:0] flags;} row_s;
    row_s rows [7] = '{'{0, 0, 8'h01, 4'h1, 1'b1, 4'h1, 32'h1},
        '{1, 7, 8'h80, 4'h2, 1'b1, 4'h2, 32'h2}, '{2, 3, 8'h08, 4'h4, 1'b1, 4'h4, 32'h4},
        '{3, 5, 8'h20, 4'h8, 1'b1, 4'h8, 32'h8}, '{3, 6, 8'h20, 4'h8, 1'b1, 4'h0, 32'h0},
        '{2, 3, 8'h08, 4'h0, 1'b1, 4'h0, 32'h4}, '{1, 7, 8'h80, 4'h2, 1'b0, 4'h0, 32'h2}};
    logic [7:0] mask_idx [4] = '{pin_change_pkg::MASK_GROUP0_IDX,
        pin_change_pkg::MASK_GROUP1_IDX, pin_change_pkg::MASK_GROUP2_IDX,
        pin_change_pkg::MASK_GROUP3_IDX};
    localparam logic [7:0] CTRL = pin_change_pkg::CONTROL_IDX;
    localparam logic [7:0] FLAGS = pin_change_pkg::FLAGS_IDX;

    pin_change_interrupt_unit pin_change_interrupt_unit_inst (.ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .change_pins_i(pins), .global_irq_enable_i(glob),
        .vector_ack_i(ack), .irq_req_o(irq));
    core_model core_model_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .irq_req_i(irq),
        .auto_ack_i(auto_ack), .ack_wait_i(ack_wait), .vector_ack_o(ack));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (ack !== 4'h0) begin
            acks++;
        end
    end

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_irq(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t request got %h expected %h", $time, got, exp);
        end
    endtask
    // The request is held until hready is seen, so a slow slave is served as well.
    task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rdat);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr_en;
        htrans <= pin_change_pkg::HTRANS_NONSEQ;
        do begin @(posedge ref_clk_i); end while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge ref_clk_i); end while (hready !== 1'b1);
        rdat = hrdata;
        check_reg({31'h0, hresp}, {31'h0, pin_change_pkg::HRESP_OKAY}, "bus response");
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0, x);
        check_reg(x, exp, what);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk_i);
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end

    initial begin
        rstn_i = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; pins = 32'h0; glob = 1'b0; auto_ack = 1'b0;
        ack_wait = 8'h00;
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
        check_irq(irq, 4'h0);
        rd_chk(CTRL, 32'h0, "control reset");
        rd_chk(FLAGS, 32'h0, "flags reset");
        rd_chk(8'h00, 32'h0, "unmapped read");
        for (int g = 0; g < 4; g++) begin
            rd_chk(mask_idx[g], 32'h0, "mask reset");
            wr(mask_idx[g], 32'h1a5 ^ g);
            rd_chk(mask_idx[g], 32'ha5 ^ g, "mask read back");
        end
        foreach (rows[i]) begin
            wr(mask_idx[rows[i].grp], {24'h0, rows[i].mask});
            wr(CTRL, {28'h0, rows[i].ctrl});
            glob <= rows[i].gie;
            pins <= pins ^ (32'h1 << (8 * rows[i].grp + rows[i].pin));
            repeat (5) @(posedge ref_clk_i);
            check_irq(irq, rows[i].irq);
            rd_chk(FLAGS, rows[i].flags, "row flags");
            wr(FLAGS, 32'hf);
            rd_chk(FLAGS, 32'h0, "row clear");
        end
        // Two groups held at once; control enables group 1 only, global enable is off.
        pins <= pins ^ 32'h0000_8001;
        repeat (5) @(posedge ref_clk_i);
        check_irq(irq, 4'h0);
        rd_chk(FLAGS, 32'h3, "two flags");
        wr(FLAGS, 32'h0);
        rd_chk(FLAGS, 32'h3, "zero write");
        wr(FLAGS, 32'hf0);
        rd_chk(FLAGS, 32'h3, "upper bits");
        glob <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        check_irq(irq, 4'h2);
        wr(FLAGS, 32'h1);
        rd_chk(FLAGS, 32'h2, "clear one");
        wr(FLAGS, 32'h2);
        repeat (2) @(posedge ref_clk_i);
        check_irq(irq, 4'h0);
        // The core now answers, first at once and then late.
        auto_ack <= 1'b1;
        wr(CTRL, 32'hf);
        for (int w = 0; w < 12; w += 6) begin
            ack_wait <= 8'(w);
            pins <= pins ^ 32'h0000_8000;
            repeat (20) @(posedge ref_clk_i);
            check_irq(irq, 4'h0);
            rd_chk(FLAGS, 32'h0, "served flag");
        end
        check_reg(acks, 32'h2, "routine count");
        rstn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
        check_irq(irq, 4'h0);
        rd_chk(mask_idx[3], 32'h0, "mask second reset");
        rd_chk(CTRL, 32'h0, "control second reset");
        results();
    end
endmodule
